// ==== hw/acal_consts.vh ====
// Constants of the auxiliary converter calibration datapath
// Behaviour
// - Offset correction is one 16-bit word built from two byte registers.
// - Offset low byte at 17h, high byte at 18h, both reset to zero.
// - Offset is two's complement, left-shifted to the top of the 24-bit result.
// - Aligned offset is subtracted before gain scaling from each raw result except one arriving in ST_SUB, which is dropped.
// - Gain low byte at 19h, high byte at 1Ah, resetting to 00h and 40h.
// - Gain word is an unsigned straight binary quantity.
// - Gain factor is gain word divided by 4000h; reset value gives unity.
// - Offset-corrected result is multiplied by the gain factor for output.
`ifndef ACAL_CONSTS_VH
`define ACAL_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define ACAL_ADDR_W          8
`define ACAL_ADDR_OFS_LO     8'h17
`define ACAL_ADDR_OFS_HI     8'h18
`define ACAL_ADDR_GAIN_LO    8'h19
`define ACAL_ADDR_GAIN_HI    8'h1a
`define ACAL_ADDR_RESULT_LO  8'h1b
`define ACAL_ADDR_RESULT_MID 8'h1c
`define ACAL_ADDR_RESULT_HI  8'h1d

// ****************************************
// Reset values and arithmetic
// ****************************************
`define ACAL_RST_OFS_LO      8'h00
`define ACAL_RST_OFS_HI      8'h00
`define ACAL_RST_GAIN_LO     8'h00
`define ACAL_RST_GAIN_HI     8'h40
`define ACAL_RAW_W           24
`define ACAL_WORD_W          16
`define ACAL_GAIN_SHIFT      14
`define ACAL_MAX_POS         24'h7fffff
`define ACAL_MAX_NEG         24'h800000

`endif

// ==== hw/acal_regbank.v ====
// Byte-wide calibration word storage, registered read-out
`timescale 1ns/1ps
`default_nettype none
`include "acal_consts.vh"
module acal_regbank #(
   parameter [7:0] RST_LO = 8'h00,
   parameter [7:0] RST_HI = 8'h00
) (
   // Clock and reset
   input  wire        mclk,
   input  wire        nrst,
   // Byte writes
   input  wire        wr_lo,
   input  wire        wr_hi,
   input  wire [7:0]  wdata,
   // Stored word
   output reg  [15:0] word
);
   // Two byte halves forming one word
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         word <= {RST_HI, RST_LO};
      end else begin
         if (wr_lo) begin
            word[7:0] <= wdata;
         end
         if (wr_hi) begin
            word[15:8] <= wdata;
         end
      end
   end
endmodule
`default_nettype wire

// ==== hw/acal_top.v ====
// Calibration datapath of the auxiliary converter with its register port
`timescale 1ns/1ps
`default_nettype none
`include "acal_consts.vh"
module acal_top #(
   parameter RAW_W = `ACAL_RAW_W
) (
   // Clock and reset
   input  wire             mclk,
   input  wire             nrst,
   // Register port
   input  wire [7:0]       addr,
   input  wire [7:0]       wdata,
   input  wire             wr,
   input  wire             rd,
   output reg  [7:0]       rdata,
   // Raw results from the modulator filter
   input  wire [RAW_W-1:0] raw_data,
   input  wire             raw_valid,
   // Calibrated results
   output reg  [RAW_W-1:0] cal_data,
   output reg              cal_valid,
   output reg              cal_clipped
);
   // ****************************************
   // States of the two-stage pipeline
   // ****************************************
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_SUB  = 3'b010;
   localparam [2:0] ST_MUL  = 3'b100;

   localparam PROD_W = RAW_W + 2 + `ACAL_WORD_W + 1;

   wire [15:0] aux_offset_word;
   wire [15:0] aux_gain_word;
   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [RAW_W-1:0] raw_hold;
   reg  [15:0] ofs_snap;
   reg  [15:0] gain_snap;
   reg  signed [RAW_W+1:0] diff;
   wire signed [RAW_W+1:0] raw_ext;
   wire signed [RAW_W+1:0] ofs_ext;
   wire signed [PROD_W-1:0] prod;
   wire signed [PROD_W-1:0] scaled;
   wire signed [PROD_W-1:0] lim_pos;
   wire signed [PROD_W-1:0] lim_neg;

   // ****************************************
   // Calibration word storage
   // ****************************************
   acal_regbank #(
      .RST_LO (`ACAL_RST_OFS_LO),
      .RST_HI (`ACAL_RST_OFS_HI)
   ) u_ofs (
      .mclk  (mclk),
      .nrst  (nrst),
      .wr_lo (wr && addr == `ACAL_ADDR_OFS_LO),
      .wr_hi (wr && addr == `ACAL_ADDR_OFS_HI),
      .wdata (wdata),
      .word  (aux_offset_word)
   );

   acal_regbank #(
      .RST_LO (`ACAL_RST_GAIN_LO),
      .RST_HI (`ACAL_RST_GAIN_HI)
   ) u_gain (
      .mclk  (mclk),
      .nrst  (nrst),
      .wr_lo (wr && addr == `ACAL_ADDR_GAIN_LO),
      .wr_hi (wr && addr == `ACAL_ADDR_GAIN_HI),
      .wdata (wdata),
      .word  (aux_gain_word)
   );

   // ****************************************
   // Register read-out, data in the next cycle
   // ****************************************
   // Unmapped addresses read as zero
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            `ACAL_ADDR_OFS_LO:     rdata <= aux_offset_word[7:0];
            `ACAL_ADDR_OFS_HI:     rdata <= aux_offset_word[15:8];
            `ACAL_ADDR_GAIN_LO:    rdata <= aux_gain_word[7:0];
            `ACAL_ADDR_GAIN_HI:    rdata <= aux_gain_word[15:8];
            `ACAL_ADDR_RESULT_LO:  rdata <= cal_data[7:0];
            `ACAL_ADDR_RESULT_MID: rdata <= cal_data[15:8];
            `ACAL_ADDR_RESULT_HI:  rdata <= cal_data[RAW_W-1:16];
            default:               rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ****************************************
   // Arithmetic
   // ****************************************
   // Offset left-aligned to the top of the raw word, low bits zero
   assign raw_ext = {{2{raw_hold[RAW_W-1]}}, raw_hold};
   assign ofs_ext = {{2{ofs_snap[15]}}, ofs_snap, {(RAW_W-16){1'b0}}};
   // Gain word zero-extended, so it never reads as negative
   assign prod    = diff * $signed({1'b0, gain_snap});
   // Division by 4000h is an arithmetic shift; truncates toward minus infinity
   assign scaled  = prod >>> `ACAL_GAIN_SHIFT;
   assign lim_pos = $signed({{(PROD_W-RAW_W){1'b0}}, `ACAL_MAX_POS});
   assign lim_neg = $signed({{(PROD_W-RAW_W){1'b1}}, `ACAL_MAX_NEG});

   // ****************************************
   // Pipeline control
   // ****************************************
   // A new raw word in ST_MUL starts again at once; one arriving in ST_SUB is dropped
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (raw_valid) begin
               next_state = ST_SUB;
            end
         end
         ST_SUB:  next_state = ST_MUL;
         ST_MUL: begin
            next_state = raw_valid ? ST_SUB : ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Capture raw word with the settings current at completion
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         raw_hold  <= {RAW_W{1'b0}};
         ofs_snap  <= {`ACAL_RST_OFS_HI, `ACAL_RST_OFS_LO};
         gain_snap <= {`ACAL_RST_GAIN_HI, `ACAL_RST_GAIN_LO};
      end else if (raw_valid && state != ST_SUB) begin
         raw_hold  <= raw_data;
         ofs_snap  <= aux_offset_word;
         gain_snap <= aux_gain_word;
      end
   end

   // Offset step precedes scaling
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         diff <= {(RAW_W+2){1'b0}};
      end else if (state == ST_SUB) begin
         diff <= raw_ext - ofs_ext;
      end
   end

   // Saturating output stage; wrap would flip the sign of big values
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cal_data    <= {RAW_W{1'b0}};
         cal_valid   <= 1'b0;
         cal_clipped <= 1'b0;
      end else begin
         cal_valid <= (state == ST_MUL);
         if (state == ST_MUL) begin
            if (scaled > lim_pos) begin
               cal_data    <= `ACAL_MAX_POS;
               cal_clipped <= 1'b1;
            end else if (scaled < lim_neg) begin
               cal_data    <= `ACAL_MAX_NEG;
               cal_clipped <= 1'b1;
            end else begin
               cal_data    <= scaled[RAW_W-1:0];
               cal_clipped <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/acal_assertions.sv ====
// Concurrent checks on the calibration datapath ports
`timescale 1ns/1ps
`default_nettype none
module acal_assertions #(parameter RAW_W = 24) (
   // Clock and reset
   input wire logic             mclk,
   input wire logic             nrst,
   // Register port
   input wire logic [7:0]       addr,
   input wire logic [7:0]       wdata,
   input wire logic             wr,
   input wire logic             rd,
   input wire logic [7:0]       rdata,
   // Datapath
   input wire logic [RAW_W-1:0] raw_data,
   input wire logic             raw_valid,
   input wire logic [RAW_W-1:0] cal_data,
   input wire logic             cal_valid,
   input wire logic             cal_clipped
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Byte write straight followed by a read of the same place
   sequence s_wr_rd;
      wr && addr >= 8'h17 && addr <= 8'h1a ##1 rd && $stable(addr);
   endsequence
   chk_cal_latency: assert property (cal_valid |-> $past(raw_valid, 3))
      else $error("result without a sample three cycles before");
   chk_valid_pulse: assert property (cal_valid |=> !cal_valid)
      else $error("result strobe longer than one cycle");
   chk_result_hold: assert property (!cal_valid |-> $stable(cal_data) && $stable(cal_clipped))
      else $error("result moved without a strobe");
   chk_clip_value: assert property (cal_clipped |-> cal_data == 24'h7fffff || cal_data == 24'h800000)
      else $error("clipped result not at a range end");
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside the answer cycle");
   chk_unmapped_rd: assert property ($past(rd) && ($past(addr) < 8'h17 || $past(addr) > 8'h1d) |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_wr_readback: assert property (s_wr_rd |=> rdata == $past(wdata, 2))
      else $error("calibration byte not read back");
   chk_result_rd: assert property ($past(rd) && $past(addr) == 8'h1d && !cal_valid |-> rdata == cal_data[23:16])
      else $error("result top byte read back wrong");
endmodule
bind acal_top acal_assertions #(.RAW_W(RAW_W)) u_acal_assertions (.mclk(mclk), .nrst(nrst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .raw_data(raw_data), .raw_valid(raw_valid),
   .cal_data(cal_data), .cal_valid(cal_valid), .cal_clipped(cal_clipped));
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the calibration datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        mclk = 0, nrst = 0, wr = 0, rd = 0, raw_valid = 0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
   logic [23:0] raw_data = 24'h000000, cal_data;
   logic        cal_valid, cal_clipped;
   logic [24:0] e;
   int          n_fail = 0, comparisons = 0, cyc = 0, i;
   // Rows: gain word, offset word, raw sample, expected {clip flag, result}
   logic [87:0] rows [8] = '{88'h4000_0000_123456_00123456, 88'h4000_0000_876543_00876543,
      88'h4000_0100_000000_00ff0000, 88'h4000_ff00_000000_00010000, 88'h8000_0000_500000_017fffff,
      88'h8000_0000_a00000_01800000, 88'h0000_0000_7fffff_00000000, 88'hffff_0000_100000_003fffc0};
   always #20 mclk = ~mclk;
   acal_top u_acal_top (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .raw_data(raw_data), .raw_valid(raw_valid), .cal_data(cal_data),
      .cal_valid(cal_valid), .cal_clipped(cal_clipped));
   // ****************************************
   // Reference model and bus tasks
   // ****************************************
   // Floor shift matches the datapath, so rounding never differs
   function automatic logic [24:0] calc(input logic [15:0] o, g, input logic [23:0] r);
      longint v;
      v = ((longint'($signed(r)) - longint'($signed(o)) * 256) * longint'(g)) >>> 14;
      if (v > 64'sh7fffff) return {1'b1, 24'h7fffff};
      if (v < -64'sh800000) return {1'b1, 24'h800000};
      return {1'b0, v[23:0]};
   endfunction
   task automatic check(input logic [25:0] s, x);
      comparisons++;
      if (s !== x) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, x);
      end
   endtask
   task final_report;
      if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Strobes stay up across calls so no signal is set twice per step
   task automatic wr_reg(input logic [7:0] a, d);
      wr <= 1; rd <= 0; addr <= a; wdata <= d;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, x);
      rd <= 1; wr <= 0; addr <= a;
      @(posedge mclk);
      fork begin #1 check(rdata, x); end join_none
   endtask
   task automatic prog(input logic [15:0] o, g);
      wr_reg(8'h17, o[7:0]); wr_reg(8'h18, o[15:8]); wr_reg(8'h19, g[7:0]); wr_reg(8'h1a, g[15:8]);
   endtask
   task automatic fire(input logic [23:0] r);
      wr <= 0; rd <= 0; raw_valid <= 1; raw_data <= r;
      @(posedge mclk);
   endtask
   // Bounded wait for the result strobe, then compare strobe, flag and data
   task automatic grab(input logic [24:0] x);
      wr <= 0; rd <= 0; raw_valid <= 0;
      for (int k = 0; k < 8 && cal_valid !== 1'b1; k++) @(posedge mclk) #1;
      check({cal_valid, cal_clipped, cal_data}, {1'b1, x});
      @(posedge mclk);
   endtask
   always @(posedge mclk) if (++cyc == 2000) begin n_fail++; final_report; end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge mclk);
      nrst <= 1;
      for (i = 0; i < 4; i++) rd_chk(8'(8'h17 + i), i == 3 ? 8'h40 : 8'h00);
      foreach (rows[i]) begin
         prog(rows[i][71:56], rows[i][87:72]);
         fire(rows[i][55:32]);
         e = rows[i][24:0];
         grab(e);
      end
      for (i = 0; i < 3; i++) rd_chk(8'(8'h1b + i), e[8*i+:8]);
      wr_reg(8'h18, 8'ha5);
      rd_chk(8'h18, 8'ha5);
      wr_reg(8'h1e, 8'hff);
      rd_chk(8'h1e, 8'h00);
      rd_chk(8'h16, 8'h00);
      // Write landing with a sample keeps the old gain for that sample
      prog(16'h0000, 16'h4000);
      raw_valid <= 1; raw_data <= 24'h200000;
      wr_reg(8'h1a, 8'h20);
      grab(calc(16'h0000, 16'h4000, 24'h200000));
      // Second sample one cycle later is dropped
      fire(24'h100000);
      fire(24'h300000);
      grab(calc(16'h0000, 16'h2000, 24'h100000));
      repeat (3) begin @(posedge mclk) #1; check(cal_valid, 0); end
      // Nonzero offset byte, so the reset below has something to clear
      @(posedge mclk);
      wr_reg(8'h18, 8'h3c);
      nrst <= 0;
      repeat (4) @(posedge mclk);
      nrst <= 1;
      rd_chk(8'h1a, 8'h40);
      rd_chk(8'h18, 8'h00);
      rd <= 0;
      repeat (2) @(posedge mclk);
      final_report;
   end
endmodule
`default_nettype wire
